// file: hw/ddsp_channel.v
`timescale 1ns/100ps
`include "ddsp_regs.vh"
module ddsp_channel (
    input  wire       core_clk_in,
    input  wire       rst_in,
    input  wire       ref_tick_in,
    input  wire       sel_in,
    input  wire       wr_in,
    input  wire       rd_in,
    input  wire [2:0] addr_in,
    input  wire [7:0] wdata_in,
    input  wire       two_wire_in,
    input  wire       auto_dir_in,
    input  wire       rx_in,
    output reg  [7:0] rdata_out,
    output reg        tx_out,
    output reg        tx_en_out,
    output reg        irq_out
);

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg  [7:0]  lcr_reg;
reg  [7:0]  mcr_reg;
reg  [15:0] div_reg;
reg  [7:0]  thr_reg;
reg         thr_full_reg;
reg  [7:0]  rbr_reg;
reg         dr_reg;
reg         rx_s1_reg;
reg         rx_s2_reg;
reg  [15:0] bdiv_cnt_reg;
reg         tick16_reg;
// transmitter
reg  [1:0]  tx_st_reg;
reg  [3:0]  tx_os_reg;
reg  [3:0]  tx_bit_reg;
reg  [7:0]  tx_sh_reg;
// receiver
reg  [1:0]  rx_st_reg;
reg  [3:0]  rx_os_reg;
reg  [3:0]  rx_bit_reg;
reg  [7:0]  rx_sh_reg;

localparam ST_IDLE  = 2'd0;
localparam ST_START = 2'd1;
localparam ST_DATA  = 2'd2;
localparam ST_STOP  = 2'd3;

wire       divisor_latch_select = lcr_reg[`DDSP_LCR_DLS];
wire [3:0] nbits     = {2'b00, lcr_reg[1:0]} + 4'd5;
wire       wr_data   = sel_in & wr_in & addr_in == `DDSP_OFF_DATA &
                       ~divisor_latch_select;
wire       rd_data   = sel_in & rd_in & addr_in == `DDSP_OFF_DATA &
                       ~divisor_latch_select;
wire       tx_busy   = tx_st_reg != ST_IDLE;
wire       rx_line   = two_wire_in ? 1'b1 : rx_s2_reg;

// ----------------------------------------------------------------
// bus writes to line, modem, divisor and holding registers
// ----------------------------------------------------------------
always @(posedge core_clk_in) begin
    if (rst_in) begin
        lcr_reg <= `DDSP_LCR_RST;
        mcr_reg <= `DDSP_MCR_RST;
        div_reg <= `DDSP_DIV_RST;
        thr_reg <= 8'h00;
    end else if (sel_in & wr_in) begin
        case (addr_in)
            `DDSP_OFF_DATA: begin
                if (divisor_latch_select)
                    div_reg[7:0] <= wdata_in;
                else
                    thr_reg <= wdata_in;
            end
            `DDSP_OFF_DIVHI: begin
                if (divisor_latch_select)
                    div_reg[15:8] <= wdata_in;
            end
            `DDSP_OFF_LCR: lcr_reg <= wdata_in;
            `DDSP_OFF_MCR: mcr_reg <= wdata_in;
            default: ;
        endcase
    end
end

// ----------------------------------------------------------------
// read mux
// ----------------------------------------------------------------
always @(posedge core_clk_in) begin
    if (rst_in)
        rdata_out <= 8'h00;
    else if (sel_in & rd_in) begin
        case (addr_in)
            `DDSP_OFF_DATA:  rdata_out <= divisor_latch_select ?
                div_reg[7:0] : rbr_reg;
            `DDSP_OFF_DIVHI: rdata_out <= divisor_latch_select ?
                div_reg[15:8] : 8'h00;
            `DDSP_OFF_IID:   rdata_out <= dr_reg ? `DDSP_IID_RXAVAIL :
                (~thr_full_reg ? `DDSP_IID_THRE : `DDSP_IID_NONE);
            `DDSP_OFF_LCR:   rdata_out <= lcr_reg;
            `DDSP_OFF_MCR:   rdata_out <= mcr_reg;
            `DDSP_OFF_LSR:   rdata_out <= {1'b0, ~thr_full_reg & ~tx_busy,
                ~thr_full_reg, 4'h0, dr_reg};
            default:         rdata_out <= 8'h00;
        endcase
    end
end

// ----------------------------------------------------------------
// baud tick: reference tick / divisor, then /16 in the shifters
// ----------------------------------------------------------------
always @(posedge core_clk_in) begin
    if (rst_in) begin
        bdiv_cnt_reg <= 16'h0001;
        tick16_reg   <= 1'b0;
    end else begin
        tick16_reg <= 1'b0;
        if (ref_tick_in) begin
            // divisor zero treated as one
            if (bdiv_cnt_reg >= div_reg) begin
                bdiv_cnt_reg <= 16'h0001;
                tick16_reg   <= 1'b1;
            end else
                bdiv_cnt_reg <= bdiv_cnt_reg + 16'h0001;
        end
    end
end

// ----------------------------------------------------------------
// transmitter
// ----------------------------------------------------------------
always @(posedge core_clk_in) begin
    if (rst_in) begin
        tx_st_reg    <= ST_IDLE;
        tx_os_reg    <= 4'h0;
        tx_bit_reg   <= 4'h0;
        tx_sh_reg    <= 8'h00;
        tx_out       <= 1'b1;
        thr_full_reg <= 1'b0;
    end else begin
        if (wr_data)
            thr_full_reg <= 1'b1;
        case (tx_st_reg)
            ST_IDLE: begin
                tx_out <= 1'b1;
                if (thr_full_reg & tick16_reg) begin
                    tx_sh_reg    <= thr_reg;
                    thr_full_reg <= wr_data;
                    tx_st_reg    <= ST_START;
                    tx_os_reg    <= 4'h0;
                    tx_out       <= 1'b0;
                end
            end
            ST_START, ST_DATA, ST_STOP: begin
                if (tick16_reg) begin
                    tx_os_reg <= tx_os_reg + 4'h1;
                    if (tx_os_reg == `DDSP_OVERSAMPLE) begin
                        tx_os_reg <= 4'h0;
                        if (tx_st_reg == ST_START) begin
                            tx_st_reg  <= ST_DATA;
                            tx_bit_reg <= 4'h0;
                            tx_out     <= tx_sh_reg[0];
                        end else if (tx_st_reg == ST_DATA) begin
                            tx_bit_reg <= tx_bit_reg + 4'h1;
                            tx_sh_reg  <= {1'b0, tx_sh_reg[7:1]};
                            if (tx_bit_reg + 4'h1 == nbits) begin
                                tx_st_reg  <= ST_STOP;
                                tx_bit_reg <= 4'h0;
                                tx_out     <= 1'b1;
                            end else
                                tx_out <= tx_sh_reg[1];
                        end else begin
                            tx_bit_reg <= tx_bit_reg + 4'h1;
                            if (tx_bit_reg[0] |
                                ~lcr_reg[`DDSP_LCR_STOP])
                                tx_st_reg <= ST_IDLE;
                        end
                    end
                end
            end
            default: tx_st_reg <= ST_IDLE;
        endcase
    end
end

// ----------------------------------------------------------------
// receiver
// ----------------------------------------------------------------
always @(posedge core_clk_in) begin
    if (rst_in) begin
        rx_s1_reg  <= 1'b1;
        rx_s2_reg  <= 1'b1;
        rx_st_reg  <= ST_IDLE;
        rx_os_reg  <= 4'h0;
        rx_bit_reg <= 4'h0;
        rx_sh_reg  <= 8'h00;
        rbr_reg    <= 8'h00;
        dr_reg     <= 1'b0;
    end else begin
        rx_s1_reg <= rx_in;
        rx_s2_reg <= rx_s1_reg;
        if (rd_data)
            dr_reg <= 1'b0;
        case (rx_st_reg)
            ST_IDLE: begin
                rx_os_reg <= 4'h0;
                if (tick16_reg & ~rx_line)
                    rx_st_reg <= ST_START;
            end
            ST_START: begin
                if (tick16_reg) begin
                    rx_os_reg <= rx_os_reg + 4'h1;
                    if (rx_os_reg == `DDSP_MID_SAMPLE) begin
                        rx_os_reg  <= 4'h0;
                        rx_bit_reg <= 4'h0;
                        // false start glitch returns to idle
                        rx_st_reg  <= rx_line ? ST_IDLE : ST_DATA;
                    end
                end
            end
            ST_DATA, ST_STOP: begin
                if (tick16_reg) begin
                    rx_os_reg <= rx_os_reg + 4'h1;
                    if (rx_os_reg == `DDSP_OVERSAMPLE) begin
                        rx_os_reg <= 4'h0;
                        if (rx_st_reg == ST_DATA) begin
                            rx_sh_reg  <= {rx_line, rx_sh_reg[7:1]};
                            rx_bit_reg <= rx_bit_reg + 4'h1;
                            if (rx_bit_reg + 4'h1 == nbits)
                                rx_st_reg <= ST_STOP;
                        end else begin
                            // align short characters to bit 0
                            rbr_reg   <= rx_sh_reg >> (4'd8 - nbits);
                            dr_reg    <= 1'b1;
                            rx_st_reg <= ST_IDLE;
                        end
                    end
                end
            end
            default: rx_st_reg <= ST_IDLE;
        endcase
    end
end

// ----------------------------------------------------------------
// driver enable and interrupt gate
// ----------------------------------------------------------------
always @(posedge core_clk_in) begin
    if (rst_in) begin
        tx_en_out <= 1'b0;
        irq_out   <= 1'b0;
    end else begin
        if (two_wire_in & auto_dir_in)
            tx_en_out <= thr_full_reg | tx_busy;
        else if (two_wire_in)
            tx_en_out <= mcr_reg[`DDSP_MCR_RTS];
        else
            tx_en_out <= 1'b1;
        irq_out <= mcr_reg[`DDSP_MCR_AUX2] &
                   (dr_reg | ~thr_full_reg);
    end
end

endmodule // ddsp_channel

// file: hw/ddsp_regs.vh
`ifndef DDSP_REGS_VH
`define DDSP_REGS_VH
// register offsets within one channel
`define DDSP_OFF_DATA      3'h0
`define DDSP_OFF_DIVHI     3'h1
`define DDSP_OFF_IID       3'h2
`define DDSP_OFF_LCR       3'h3
`define DDSP_OFF_MCR       3'h4
`define DDSP_OFF_LSR       3'h5
// field positions
`define DDSP_LCR_DLS       7
`define DDSP_LCR_STOP      2
`define DDSP_MCR_RTS       1
`define DDSP_MCR_AUX2      3
`define DDSP_LSR_DR        0
`define DDSP_LSR_THRE      5
`define DDSP_LSR_TEMT      6
// reset values
`define DDSP_LCR_RST       8'h03
`define DDSP_MCR_RST       8'h00
`define DDSP_DIV_RST       16'h000C
// identification readouts
`define DDSP_IID_NONE      8'h01
`define DDSP_IID_RXAVAIL   8'h04
`define DDSP_IID_THRE      8'h02
// sixteen divided (tick16) ticks per bit, each one divisor count of reference ticks
`define DDSP_OVERSAMPLE    4'hF
`define DDSP_MID_SAMPLE    4'h7
`endif

// file: hw/ddsp_top.v
`timescale 1ns/100ps
`include "ddsp_regs.vh"
// ----------------------------------------------------------------
// Notes on behaviour
// ----------------------------------------------------------------
// Notes on behaviour
// - two channels, eight byte registers each; six decoded here, offsets 6 and 7 read zero
// - line control bit 7 maps divisor
// - divisor low at 0, high at 1
// - reference 1.8432 or 7.3728 MHz by jumper
// - bit rate is reference over sixteen times divisor
// - length bits 1:0 equal length minus five
// - bit 2 picks one or two stops
// - bits 3 to 6 parity, break; keep zero
// - modem control bit 1 is request-to-send
// - request-to-send steers transceiver direction only
// - auto mode enables driver while data pending
// - modem bit 3 gates interrupt output
// - status bit 0 shows received data waiting
// - status bit 5 shows holding register empty
// - identification reads 4 for received data
// - jumper picks four-wire or two-wire mode
module ddsp_top #(
    parameter CORE_HZ = 20000000,
    parameter REF_X1_HZ = 1843200,
    parameter REF_X4_HZ = 7372800
) (
    input  wire       core_clk_in,
    input  wire       rst_in,
    input  wire       sel_a_in,
    input  wire       sel_b_in,
    input  wire       wr_in,
    input  wire       rd_in,
    input  wire [2:0] addr_in,
    input  wire [7:0] wdata_in,
    input  wire       clock_multiplier_select_in,
    input  wire [1:0] two_wire_mode_in,
    input  wire [1:0] auto_dir_in,
    input  wire [1:0] rx_in,
    output reg  [7:0] rdata_out,
    output wire [1:0] tx_out,
    output wire [1:0] tx_en_out,
    output reg        irq_out
);

// ----------------------------------------------------------------
// reference tick by phase accumulation
// ----------------------------------------------------------------
// fractional accumulator gives the exact mean rate at 20 MHz
localparam [31:0] STEP_X1 = REF_X1_HZ;
localparam [31:0] STEP_X4 = REF_X4_HZ;
localparam [31:0] WRAP    = CORE_HZ;

reg  [1:0]  jmp_s1_reg;
reg  [1:0]  jmp_s2_reg;
reg  [31:0] acc_reg;
reg         ref_tick_reg;
wire [31:0] step = jmp_s2_reg[0] ? STEP_X4 : STEP_X1;
wire [32:0] acc_sum = {1'b0, acc_reg} + {1'b0, step};

always @(posedge core_clk_in) begin
    if (rst_in) begin
        jmp_s1_reg   <= 2'b00;
        jmp_s2_reg   <= 2'b00;
        acc_reg      <= 32'h00000000;
        ref_tick_reg <= 1'b0;
    end else begin
        jmp_s1_reg <= {1'b0, clock_multiplier_select_in};
        jmp_s2_reg <= jmp_s1_reg;
        if (acc_sum >= {1'b0, WRAP}) begin
            acc_reg      <= acc_sum[31:0] - WRAP;
            ref_tick_reg <= 1'b1;
        end else begin
            acc_reg      <= acc_sum[31:0];
            ref_tick_reg <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------
// channels
// ----------------------------------------------------------------
wire [7:0] ch_rdata [0:1];
wire [1:0] ch_irq;
wire [1:0] ch_sel = {sel_b_in, sel_a_in};
reg        rd_b_reg;
reg  [3:0] mode_s1_reg;
reg  [3:0] mode_s2_reg;

// jumpers are pins; no reset, so they settle while reset is held
always @(posedge core_clk_in) begin
    mode_s1_reg <= {auto_dir_in, two_wire_mode_in};
    mode_s2_reg <= mode_s1_reg;
end

genvar g;
generate
    for (g = 0; g < 2; g = g + 1) begin : g_ch
        ddsp_channel u_ch (
            .core_clk_in (core_clk_in),
            .rst_in      (rst_in),
            .ref_tick_in (ref_tick_reg),
            .sel_in      (ch_sel[g]),
            .wr_in       (wr_in),
            .rd_in       (rd_in),
            .addr_in     (addr_in),
            .wdata_in    (wdata_in),
            .two_wire_in (mode_s2_reg[g]),
            .auto_dir_in (mode_s2_reg[g+2]),
            .rx_in       (rx_in[g]),
            .rdata_out   (ch_rdata[g]),
            .tx_out      (tx_out[g]),
            .tx_en_out   (tx_en_out[g]),
            .irq_out     (ch_irq[g])
        );
    end
endgenerate

// ----------------------------------------------------------------
// shared read data and interrupt
// ----------------------------------------------------------------
always @(posedge core_clk_in) begin
    if (rst_in) begin
        rd_b_reg <= 1'b0;
        irq_out  <= 1'b0;
    end else begin
        if (rd_in & (sel_a_in | sel_b_in))
            rd_b_reg <= sel_b_in;
        irq_out <= |ch_irq;
    end
end

always @* begin
    rdata_out = rd_b_reg ? ch_rdata[1] : ch_rdata[0];
end

endmodule // ddsp_top

// file: testbench/ddsp_props.sv
`timescale 1ns/100ps
module ddsp_props (
    input wire       core_clk_in,
    input wire       rst_in,
    input wire       sel_a_in,
    input wire       sel_b_in,
    input wire       wr_in,
    input wire       rd_in,
    input wire [2:0] addr_in,
    input wire [7:0] wdata_in,
    input wire [1:0] two_wire_mode_in,
    input wire [1:0] auto_dir_in,
    input wire [7:0] rdata_out,
    input wire [1:0] tx_out,
    input wire [1:0] tx_en_out,
    input wire       irq_out
);
    reg  [7:0] low_run;
    reg        aux_seen;
    wire       rts_wr;
    assign rts_wr = wr_in && sel_a_in && addr_in == 3'h4;
    // saturating run of low line cycles, shortest legal bit is ~43
    always @(posedge core_clk_in) begin
        if (rst_in || tx_out[0])
            low_run <= 8'h00;
        else if (low_run != 8'hFF)
            low_run <= low_run + 8'h01;
        if (rst_in)
            aux_seen <= 1'b0;
        else if (wr_in && (sel_a_in || sel_b_in) && addr_in == 3'h4
                 && wdata_in[3])
            aux_seen <= 1'b1;
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    sequence s_rd_hole;
        rd_in && (sel_a_in || sel_b_in) ##0 addr_in[2:1] == 2'b11;
    endsequence
    sequence s_rts_on;
        rts_wr && wdata_in[1] ##0 two_wire_mode_in[0] && !auto_dir_in[0];
    endsequence
    AST_HOLE_READS_ZERO: assert property (s_rd_hole |=> rdata_out == 8'h00)
        else $error("unmapped offset read nonzero");
    AST_RDATA_STANDS: assert property (!rd_in |=> $stable(rdata_out))
        else $error("read data moved without a read");
    AST_BIT_TIME: assert property ($rose(tx_out[0]) |-> low_run >= 8'h28)
        else $error("low line period shorter than one bit");
    AST_TXEN_FOUR_WIRE: assert property (
        !two_wire_mode_in[1] && $past(!rst_in) |-> tx_en_out[1])
        else $error("four-wire driver not enabled");
    AST_TXEN_AUTO: assert property (
        two_wire_mode_in[0] && auto_dir_in[0] && !tx_out[0] |-> tx_en_out[0])
        else $error("auto driver off while sending");
    AST_TXEN_FOLLOWS_WRITE: assert property (
        two_wire_mode_in[0] && !auto_dir_in[0] && $changed(tx_en_out[0])
        |-> $past(rts_wr) || $past(rts_wr, 2))
        else $error("manual driver moved without a write");
    AST_RTS_ON: assert property (s_rts_on |-> ##[1:3] tx_en_out[0])
        else $error("request-to-send did not enable driver");
    AST_IRQ_GATED: assert property (irq_out |-> aux_seen)
        else $error("interrupt without gate bit ever set");
endmodule // ddsp_props
bind ddsp_top ddsp_props ddsp_props_inst (
    .core_clk_in, .rst_in, .sel_a_in, .sel_b_in, .wr_in, .rd_in,
    .addr_in, .wdata_in, .two_wire_mode_in, .auto_dir_in,
    .rdata_out, .tx_out, .tx_en_out, .irq_out
);

// file: testbench/ddsp_remote_node.sv
`timescale 1ns/100ps
module ddsp_remote_node (
    input  wire       line_in,
    input  wire [3:0] nbits_in,
    input  wire       two_stop_in,
    output reg        line_out,
    output reg        got_out,
    output reg  [7:0] byte_out
);
    real    bit_ns = 2170.14;
    integer i;
    // ----
    // listener, mid-bit sampling
    // ----
    initial begin
        line_out = 1'b1;
        got_out = 1'b0;
        byte_out = 8'h00;
        forever begin
            @(negedge line_in);
            byte_out = 8'h00;
            #(bit_ns * 1.5);
            for (i = 0; i < nbits_in; i = i + 1) begin
                byte_out[i] = line_in;
                #(bit_ns);
            end
            // framing fault corrupts the byte so the compare fails
            if (!line_in)
                byte_out = ~byte_out;
            if (two_stop_in) begin
                #(bit_ns);
                if (!line_in)
                    byte_out = ~byte_out;
            end
            got_out = 1'b1;
            #10;
            got_out = 1'b0;
        end
    end
    task send(input [7:0] b);
        integer k;
        begin
            line_out = 1'b0;
            #(bit_ns);
            for (k = 0; k < 8; k = k + 1) begin
                line_out = b[k];
                #(bit_ns);
            end
            line_out = 1'b1;
            #(bit_ns * 2.0);
        end
    endtask
endmodule // ddsp_remote_node

// file: testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
    reg         core_clk_in, rst_in, sel_a_in, sel_b_in, wr_in, rd_in;
    reg         clock_multiplier_select_in, rd_pend, two_stop;
    reg  [2:0]  addr_in;
    reg  [7:0]  wdata_in, last, d, t;
    reg  [1:0]  two_wire_mode_in, auto_dir_in;
    reg  [3:0]  nbits;
    reg  [15:0] q;
    reg  [15:0] rd_q[$];
    reg  [7:0]  tx_q[$];
    wire [7:0]  rdata_out, rx_byte;
    wire [1:0]  tx_out, tx_en_out;
    wire        irq_out, node_line, rx_got;
    integer     n_fail, compares, seed, cyc, i;
    ddsp_top ddsp_top_inst (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .sel_a_in(sel_a_in),
        .sel_b_in(sel_b_in), .wr_in(wr_in), .rd_in(rd_in),
        .addr_in(addr_in), .wdata_in(wdata_in),
        .clock_multiplier_select_in(clock_multiplier_select_in),
        .two_wire_mode_in(two_wire_mode_in), .auto_dir_in(auto_dir_in),
        .rx_in({2{node_line}}), .rdata_out(rdata_out), .tx_out(tx_out),
        .tx_en_out(tx_en_out), .irq_out(irq_out));
    ddsp_remote_node node_inst (
        .line_in(tx_out[0]), .nbits_in(nbits), .two_stop_in(two_stop),
        .line_out(node_line), .got_out(rx_got), .byte_out(rx_byte));
    initial begin
        core_clk_in = 1'b0;
        forever #25 core_clk_in = ~core_clk_in;
    end
    // ----
    // result watchers
    // ----
    always @(posedge core_clk_in) begin
        cyc = cyc + 1;
        if (rd_pend) begin
            q = rd_q.pop_front();
            compares = compares + 1;
            if ((rdata_out & q[15:8]) !== (q[7:0] & q[15:8])) begin
                n_fail = n_fail + 1;
                $display("[FAIL] rdata exp %h got %h", q[7:0], rdata_out);
            end
        end
        rd_pend <= rd_in;
        if (cyc == 60000) begin
            n_fail = n_fail + 1;
            tally_and_finish;
        end
    end
    always @(posedge rx_got) begin
        t = tx_q.pop_front();
        compares = compares + 1;
        if (rx_byte !== t) begin
            n_fail = n_fail + 1;
            $display("[FAIL] tx_byte exp %h got %h", t, rx_byte);
        end
    end
    task tally_and_finish;
        begin
            if (n_fail == 0 && compares > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    task lvl(input string nm, input e, input s);
        begin
            compares = compares + 1;
            if (s !== e) begin
                n_fail = n_fail + 1;
                $display("[FAIL] %s exp %b got %b", nm, e, s);
            end
        end
    endtask
    task settle;
        begin
            repeat (2) @(posedge core_clk_in);
            #5;
        end
    endtask
    task reset;
        begin
            rst_in = 1'b1;
            repeat (5) @(posedge core_clk_in);
            #5;
            rst_in = 1'b0;
            @(posedge core_clk_in);
            #5;
        end
    endtask
    task bus(input b, input w, input [2:0] o, input [7:0] v, input [7:0] m);
        begin
            sel_a_in = !b;
            sel_b_in = b;
            wr_in = w;
            rd_in = !w;
            addr_in = o;
            wdata_in = v;
            if (!w)
                rd_q.push_back({m, v});
            @(posedge core_clk_in);
            #5;
            {sel_a_in, sel_b_in, wr_in, rd_in} = 4'h0;
            @(posedge core_clk_in);
            #5;
            last = rdata_out;
        end
    endtask
    task poll(input b, input [2:0] o, input [7:0] m);
        integer n;
        begin
            n = 0;
            last = 8'h00;
            while ((last & m) == 8'h00 && n < 12000) begin
                bus(b, 1'b0, o, 8'h00, 8'h00);
                n = n + 1;
            end
            if ((last & m) == 8'h00) begin
                n_fail = n_fail + 1;
                $display("[FAIL] poll_flag exp %h got %h", m, last & m);
            end
        end
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        seed = 32'hF514;
        n_fail = 0;
        compares = 0;
        cyc = 0;
        rd_pend = 1'b0;
        {sel_a_in, sel_b_in, wr_in, rd_in} = 4'h0;
        addr_in = 3'h0;
        wdata_in = 8'h00;
        clock_multiplier_select_in = 1'b1;
        two_wire_mode_in = 2'b01;
        auto_dir_in = 2'b01;
        nbits = 4'h8;
        two_stop = 1'b0;
        reset;
        for (i = 0; i < 2; i = i + 1) begin
            bus(i[0], 0, 3'h3, 8'h03, 8'hFF);
            bus(i[0], 0, 3'h4, 8'h00, 8'hFF);
            bus(i[0], 0, 3'h2, 8'h02, 8'hFF);
            bus(i[0], 1, 3'h5, 8'h00, 8'h00);
            bus(i[0], 0, 3'h5, 8'h60, 8'h61);
            bus(i[0], 0, 3'h6, 8'h00, 8'hFF);
            bus(i[0], 0, 3'h7, 8'h00, 8'hFF);
            bus(i[0], 1, 3'h3, 8'h80, 8'h00);
            bus(i[0], 0, 3'h0, 8'h0C, 8'hFF);
            bus(i[0], 1, 3'h1, 8'h5A, 8'h00);
            bus(i[0], 0, 3'h1, 8'h5A, 8'hFF);
            bus(i[0], 1, 3'h1, 8'h00, 8'h00);
            bus(i[0], 1, 3'h0, 8'h01, 8'h00);
            bus(i[0], 1, 3'h3, 8'h7B, 8'h00);
            bus(i[0], 0, 3'h3, 8'h7B, 8'hFF);
            bus(i[0], 1, 3'h3, 8'h03, 8'h00);
            bus(i[0], 0, 3'h0, 8'h00, 8'hFF);
            bus(i[0], 0, 3'h0, 8'h00, 8'hFF);
        end
        lvl("tx_en_b", 1'b1, tx_en_out[1]);
        lvl("tx_en_a", 1'b0, tx_en_out[0]);
        for (i = 0; i < 8; i = i + 1) begin
            poll(0, 3'h5, 8'h40);
            nbits = 4'h5 + {2'b00, i[1:0]};
            two_stop = i[2];
            bus(0, 1, 3'h3, {5'h00, i[2:0]}, 8'h00);
            repeat (2) begin
                d = $random(seed);
                tx_q.push_back(d & ~(8'hFF << nbits));
                poll(0, 3'h5, 8'h20);
                bus(0, 1, 3'h0, d, 8'h00);
            end
            bus(0, 0, 3'h5, 8'h00, 8'h20);
            bus(0, 0, 3'h2, 8'h01, 8'hFF);
            lvl("tx_en_a", 1'b1, tx_en_out[0]);
        end
        poll(0, 3'h5, 8'h40);
        settle;
        lvl("tx_en_a", 1'b0, tx_en_out[0]);
        lvl("tx_b", 1'b1, tx_out[1]);
        bus(1, 1, 3'h4, 8'h08, 8'h00);
        settle;
        lvl("irq", 1'b1, irq_out);
        bus(1, 1, 3'h4, 8'h00, 8'h00);
        settle;
        lvl("irq", 1'b0, irq_out);
        d = $random(seed);
        node_inst.send(d);
        @(posedge core_clk_in);
        #5;
        poll(1, 3'h5, 8'h01);
        bus(1, 0, 3'h2, 8'h04, 8'hFF);
        bus(1, 0, 3'h0, d, 8'hFF);
        bus(1, 0, 3'h5, 8'h00, 8'h01);
        // slow reference with the reset divisor: 9600 baud
        auto_dir_in = 2'b00;
        clock_multiplier_select_in = 1'b0;
        nbits = 4'h8;
        two_stop = 1'b0;
        node_inst.bit_ns = 104166.67;
        reset;
        settle;
        lvl("tx_en_a", 1'b0, tx_en_out[0]);
        bus(0, 1, 3'h4, 8'h02, 8'h00);
        settle;
        lvl("tx_en_a", 1'b1, tx_en_out[0]);
        d = $random(seed);
        tx_q.push_back(d);
        bus(0, 1, 3'h0, d, 8'h00);
        poll(0, 3'h5, 8'h40);
        bus(0, 1, 3'h4, 8'h00, 8'h00);
        settle;
        lvl("tx_en_a", 1'b0, tx_en_out[0]);
        tally_and_finish;
    end
endmodule // testbench
